// *** design/mrs_seq.sv ***
`timescale 1ns/1ps
// How it works
// - Reset low clears all internal logic state.
// - Reset low holds the bridge switched off.
// - Other inputs ignored while reset is low, except thermal shutdown, which still drives fault.
// - Sleep request low disables bridge, low power.
// - Sleep stops charge pump and aux regulator.
// - Sleep halts internal clocks, logic frozen.
// - Inputs other than reset and thermal ignored until sleep request returns high.
// - Overtemperature disables bridge until cooled.
// - Thermal shutdown drops bridge, pulls fault low.
// - Recovery after cooling needs no reset.
module mrs_seq
  import mrs_pkg::*;
#(
  parameter int unsigned WAKE_CNT = WAKE_CYCLES
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_logic_clear_in_n,
  input  wire logic              i_low_power_request_n,
  input  wire logic              i_thermal_shutdown,
  input  wire logic [CTRL_W-1:0] i_ctrl,
  output logic [CTRL_W-1:0]      o_ctrl,
  output mrs_power_t             o_power,
  output logic                   o_ready,
  output logic                   o_fault_indicator_n,
  output logic                   o_aux_regulator_output
);

  // Whole sequencer state and its next value. Keeping every flop outside the wake timer in one struct means the reset
  // branch and the sleep branch touch the same word, so no stray register can be missed.
  mrs_seq_t s_q;  // Registered state.
  mrs_seq_t s_d;  // Next state, filled by the one combinational process.

  // Wake timer handshakes.
  logic                  wake_start;
  logic                  wake_abort;
  logic                  wake_done;
  logic [WAKE_CNT_W-1:0] wake_count;

  // Host lines are taken as synchronous; both default low on the board, so the device idles until driven high.
  logic clear_req;
  logic sleep_req;
  assign clear_req = ~i_logic_clear_in_n;
  assign sleep_req = ~i_low_power_request_n;

  // The wake interval is measured by its own timer. It is loaded on the cycle that leaves reset
  // or sleep and aborted whenever either pin is low again, so a short pulse on a pin always
  // restarts the full settling time rather than resuming a half-finished count.
  mrs_wake_timer #(
    .CYCLES (WAKE_CNT)
  ) u_wake (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_start (wake_start),
    .i_abort (wake_abort),
    .o_done  (wake_done),
    .o_count (wake_count)
  );

  // Next-state logic. Reset has top priority, sleep next, then thermal.
  // The thermal flag is copied every cycle, whatever the state, so the fault pin reports
  // overtemperature even while the bridge is already off for another reason.
  // Priority by nesting rather than by separate flags keeps the two pins from fighting.
  always_comb begin
    s_d        = s_q;
    wake_start = 1'b0;
    wake_abort = 1'b0;
    s_d.hot    = i_thermal_shutdown;
    if (clear_req) begin
      // Internal state returns to its reset value; control inputs are not looked at.
      s_d.st       = MRS_RESET;
      s_d.ctrl     = CTRL_RST;
      s_d.wake_cnt = '0;
      wake_abort   = 1'b1;
    end else if (sleep_req) begin
      // Sleep freezes the control word; it is not reloaded until run, after the wake interval.
      s_d.st       = MRS_SLEEP;
      // The settling count is dropped as well, so a wake always starts from a full interval.
      s_d.wake_cnt = '0;
      wake_abort   = 1'b1;
    end else begin
      unique case (s_q.st)
        MRS_RESET, MRS_SLEEP: begin
          // Leaving reset or sleep starts the settling interval.
          s_d.st     = MRS_WAKE;
          wake_start = 1'b1;
        end
        MRS_WAKE: begin
          // The bridge stays off until the driver has settled.
          s_d.wake_cnt = wake_count;
          if (wake_done) begin
            s_d.st = MRS_RUN;
          end
        end
        MRS_RUN: begin
          // Control word tracks the host only while running.
          s_d.ctrl = i_ctrl;
        end
      endcase
    end
  end

  // Sleep is modelled in the next-state logic, not by gating the register: apart from the thermal flag, nothing but exit from sleep is evaluated.
  // The reset branch loads constants only; an asynchronous reset that copied a live input
  // would make the released state depend on when the reset edge happened to fall.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '{st: MRS_RESET, wake_cnt: '0, ctrl: CTRL_RST, hot: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Output enables; hot drops the bridge and recovers on its own.
  // All four are decoded from registered state only, so no pin glitch can reach the power stage.
  // Limitation: the pump and regulator stay on through a pin reset; only sleep removes them.
  always_comb begin
    o_power.bridge_en = (s_q.st == MRS_RUN) && !s_q.hot;
    o_power.pump_en   = (s_q.st != MRS_SLEEP);
    o_power.aux_en    = (s_q.st != MRS_SLEEP);
    o_power.clk_en    = (s_q.st != MRS_SLEEP);
  end

  assign o_ctrl                 = s_q.ctrl;
  assign o_ready                = (s_q.st == MRS_RUN);
  assign o_fault_indicator_n    = ~s_q.hot;
  assign o_aux_regulator_output = o_power.aux_en;

  // Reset held clears state and bridge.
  a_reset_clears: assert property (@(posedge i_clk) disable iff (i_rst)
    clear_req |=> (s_q.st == MRS_RESET) && (s_q.ctrl == CTRL_RST))
    else $error("reset did not clear state");

  a_reset_bridge_off: assert property (@(posedge i_clk) disable iff (i_rst)
    clear_req |=> !o_power.bridge_en)
    else $error("bridge on during reset");

  a_reset_ignores: assert property (@(posedge i_clk) disable iff (i_rst)
    clear_req ##1 clear_req |=> $stable(o_ctrl))
    else $error("control changed during reset");

  a_sleep_bridge: assert property (@(posedge i_clk) disable iff (i_rst)
    (sleep_req && !clear_req) |=> !o_power.bridge_en && (s_q.st == MRS_SLEEP))
    else $error("bridge on in sleep");

  a_sleep_power: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_q.st == MRS_SLEEP) |-> !o_power.pump_en && !o_aux_regulator_output)
    else $error("pump or regulator on in sleep");

  a_sleep_clk: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_q.st == MRS_SLEEP) |-> !o_power.clk_en)
    else $error("clock running in sleep");

  a_sleep_ignores: assert property (@(posedge i_clk) disable iff (i_rst)
    (sleep_req && !clear_req) ##1 (sleep_req && !clear_req) |=> $stable(o_ctrl))
    else $error("control changed in sleep");

  a_wake_delay: assert property (@(posedge i_clk) disable iff (i_rst)
    ((s_q.st == MRS_SLEEP) && !sleep_req && !clear_req) |=> !o_ready [*8])
    else $error("ready too soon after wake");

  a_hot_off: assert property (@(posedge i_clk) disable iff (i_rst)
    i_thermal_shutdown |=> !o_power.bridge_en && !o_fault_indicator_n)
    else $error("thermal shutdown not applied");

  a_hot_recover: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_ready && !i_thermal_shutdown && !clear_req && !sleep_req) |=> o_power.bridge_en && o_fault_indicator_n)
    else $error("no recovery after cooling");

  // The checks below pin down the settling interval and the frozen state in more detail.
  // They look at the timer through its count port, so a timer that skipped its load or
  // counted on through sleep would show here even when the ready output happened to be right.
  // Each one except a_reset_timer is written against registered state, never against the host pins alone.

  // Leaving reset or sleep loads the full settling count.
  a_wake_load: assert property (@(posedge i_clk) disable iff (i_rst)
    ((s_q.st inside {MRS_RESET, MRS_SLEEP}) && !clear_req && !sleep_req)
      |=> (s_q.st == MRS_WAKE) && (wake_count == WAKE_CNT_W'(WAKE_CNT)))
    else $error("wake interval not loaded");

  // No early exit from the settling interval.
  a_wake_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    ((s_q.st == MRS_WAKE) && !wake_done && !clear_req && !sleep_req) |=> (s_q.st == MRS_WAKE))
    else $error("wake interval cut short");

  // The control word is not taken while the driver settles.
  a_wake_ignores: assert property (@(posedge i_clk) disable iff (i_rst)
    ((s_q.st == MRS_WAKE) && !clear_req) |=> $stable(o_ctrl))
    else $error("control changed during wake");

  // Nothing counts while asleep.
  a_sleep_frozen: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_q.st == MRS_SLEEP) |-> (s_q.wake_cnt == '0) && (wake_count == '0))
    else $error("counter advanced in sleep");

  // A pin reset also empties the settling timer.
  a_reset_timer: assert property (@(posedge i_clk) disable iff (i_rst)
    clear_req |=> (wake_count == '0) && (s_q.wake_cnt == '0))
    else $error("timer survived reset");

  // Outside the running state the bridge is always off.
  a_idle_bridge: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_q.st != MRS_RUN) |-> !o_power.bridge_en)
    else $error("bridge on outside run");

  // A registered overtemperature always shows on the fault pin with the bridge off.
  a_hot_fault: assert property (@(posedge i_clk) disable iff (i_rst)
    s_q.hot |-> !o_power.bridge_en && !o_fault_indicator_n)
    else $error("fault pin missing overtemperature");

  // Once running, the control word follows the host one cycle late.
  a_run_tracks: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_ready && !clear_req && !sleep_req) |=> (o_ctrl == $past(i_ctrl)))
    else $error("control word not taken in run");

  // Main scenarios that the bench must reach.
  c_run: cover property (@(posedge i_clk) disable iff (i_rst) o_ready && o_power.bridge_en);
  c_sleep_wake: cover property (@(posedge i_clk) disable iff (i_rst) (s_q.st == MRS_SLEEP) ##1 (s_q.st == MRS_WAKE));
  c_hot_cycle: cover property (@(posedge i_clk) disable iff (i_rst) !o_fault_indicator_n ##1 o_fault_indicator_n);
  c_reset_wake: cover property (@(posedge i_clk) disable iff (i_rst) (s_q.st == MRS_RESET) ##1 (s_q.st == MRS_WAKE));
  c_wake_run: cover property (@(posedge i_clk) disable iff (i_rst) (s_q.st == MRS_WAKE) ##1 o_ready);

endmodule : mrs_seq

// *** design/mrs_pkg.sv ***
package mrs_pkg;

  // Clock period in picoseconds (200 MHz).
  localparam int unsigned CLK_PERIOD_PS = 5000;

  // Wake-up settling time after sleep release, in microseconds.
  localparam int unsigned WAKE_TIME_US = 1000;

  // Wake-up settling time in clock cycles, rounded up.
  localparam int unsigned WAKE_CYCLES = (WAKE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Width of the wake-up counter.
  localparam int unsigned WAKE_CNT_W = 18;

  // Width of the latched control word.
  localparam int unsigned CTRL_W = 4;

  // Control word reset value.
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

  // Operating states of the sequencer.
  typedef enum logic [1:0] {
    MRS_RESET = 2'b00,
    MRS_SLEEP = 2'b01,
    MRS_WAKE  = 2'b10,
    MRS_RUN   = 2'b11
  } mrs_state_t;

  // Power block enables.
  typedef struct packed {
    logic bridge_en;
    logic pump_en;
    logic aux_en;
    logic clk_en;
  } mrs_power_t;

  // Whole state of the sequencer.
  typedef struct packed {
    mrs_state_t             st;
    logic [WAKE_CNT_W-1:0]  wake_cnt;
    logic [CTRL_W-1:0]      ctrl;
    logic                   hot;
  } mrs_seq_t;

endpackage : mrs_pkg

// *** design/mrs_wake_timer.sv ***
`timescale 1ns/1ps
// Counts the wake-up settling interval after sleep is released.
module mrs_wake_timer
  import mrs_pkg::*;
#(
  parameter int unsigned CYCLES = WAKE_CYCLES
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_start,
  input  wire logic                  i_abort,
  output logic                       o_done,
  output logic [WAKE_CNT_W-1:0]      o_count
);

  // Whole timer state: remaining count, zero when idle or finished, and the done pulse.
  typedef struct packed {
    logic [WAKE_CNT_W-1:0] cnt;
    logic                  done;
  } mrs_timer_t;

  mrs_timer_t t_q;  // Registered timer state.
  mrs_timer_t t_d;  // Next timer state.

  // Next-value logic: abort wins, start loads, otherwise count down.
  // The done pulse lasts one cycle, so the sequencer never sees a stale finish after a restart.
  always_comb begin
    t_d      = t_q;
    t_d.done = 1'b0;
    if (i_abort) begin
      t_d.cnt = '0;
    end else if (i_start) begin
      t_d.cnt = WAKE_CNT_W'(CYCLES);
    end else if (t_q.cnt != '0) begin
      t_d.cnt  = t_q.cnt - 1'b1;
      t_d.done = (t_q.cnt == WAKE_CNT_W'(1));
    end
  end

  // Registers take constants under reset only.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign o_done  = t_q.done;
  assign o_count = t_q.cnt;

endmodule : mrs_wake_timer

// *** sim/mrs_host.sv ***
`timescale 1ns/1ps
// Host controller model that drives the reset and sleep pins.
module mrs_host (
  input  wire logic i_clk,
  output logic      o_logic_clear_in_n,
  output logic      o_low_power_request_n
);
  // Undriven pins read low, as the pull-downs hold them.
  initial begin
    o_logic_clear_in_n    = 1'b0;
    o_low_power_request_n = 1'b0;
  end
  // Pins change only just after an edge so the sequencer samples them settled.
  task automatic drive(input logic clr_n, input logic slp_n);
    @(posedge i_clk);
    o_logic_clear_in_n    <= clr_n;
    o_low_power_request_n <= slp_n;
  endtask : drive
  // The host waits out the wake-up time before it expects a working bridge.
  task automatic settle(input int unsigned cycles);
    repeat (cycles) @(posedge i_clk);
    #1;
  endtask : settle
endmodule : mrs_host

// *** sim/tb.sv ***
`timescale 1ns/1ps
// Self-checking bench for the reset and sleep sequencer.
module tb;
  import mrs_pkg::*;
  localparam int unsigned WAKE = 20;  // Short wake count keeps the run brief.
  logic              i_clk, i_rst, hot, rdy, flt_n, aux, clr_n, slp_n;
  logic [CTRL_W-1:0] ctrl, o_ctrl;
  mrs_power_t        pwr;
  int                n_mismatch = 0;
  int                tests_run = 0;
  // Packed view of all outputs: ctrl, bridge, pump, aux, clk, ready, fault_n, aux pin.
  wire  [10:0]       outs = {o_ctrl, pwr, rdy, flt_n, aux};

  mrs_host u_host (.i_clk(i_clk), .o_logic_clear_in_n(clr_n), .o_low_power_request_n(slp_n));
  mrs_seq #(.WAKE_CNT(WAKE)) u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_logic_clear_in_n(clr_n), .i_low_power_request_n(slp_n),
    .i_thermal_shutdown(hot), .i_ctrl(ctrl), .o_ctrl(o_ctrl), .o_power(pwr), .o_ready(rdy),
    .o_fault_indicator_n(flt_n), .o_aux_regulator_output(aux));

  // Compares one output word against its expected value.
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // Pin reset held: control word and sleep pin must change nothing.
  task automatic t_hold_reset();
    @(posedge i_clk);
    ctrl <= 4'hF;
    u_host.drive(1'b0, 1'b1);
    u_host.settle(4);
    chk(outs, 11'h03B);
    u_host.drive(1'b0, 1'b0);
    u_host.settle(3);
    chk(outs, 11'h03B);
  endtask : t_hold_reset

  // Release from reset; ready only after the wake count, then ctrl follows.
  task automatic t_wake();
    u_host.drive(1'b1, 1'b1);
    u_host.settle(WAKE + 1);
    chk(outs, 11'h03B);
    u_host.settle(1);
    chk(outs, 11'h07F);
    u_host.settle(2);
    chk(outs, 11'h7FF);
    @(posedge i_clk);
    ctrl <= 4'h5;
    u_host.settle(2);
    chk(outs, 11'h2FF);
  endtask : t_wake

  // Sleep freezes the control word and drops every power enable.
  task automatic t_sleep();
    u_host.drive(1'b1, 1'b0);
    @(posedge i_clk);
    ctrl <= 4'hA;
    u_host.settle(3);
    chk(outs, 11'h282);
    u_host.drive(1'b1, 1'b1);
    u_host.settle(WAKE + 1);
    chk(outs, 11'h2BB);
    u_host.settle(1);
    chk(outs, 11'h2FF);
    u_host.settle(2);
    chk(outs, 11'h57F);
  endtask : t_sleep

  // Overtemperature drops the bridge; cooling recovers with no reset.
  task automatic t_thermal();
    @(posedge i_clk);
    hot <= 1'b1;
    u_host.settle(2);
    chk(outs, 11'h53D);
    @(posedge i_clk);
    hot <= 1'b0;
    u_host.settle(2);
    chk(outs, 11'h57F);
  endtask : t_thermal

  // Clock generator at 200 MHz.
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Watchdog: the run needs well under two thousand cycles.
  initial begin
    #10000;
    n_mismatch++;
    complete_run();
  end

  // Main sequence; a mid-run pin reset closes it.
  initial begin
    i_rst = 1'b1;
    hot   = 1'b0;
    ctrl  = 4'h0;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    t_hold_reset();
    t_wake();
    t_sleep();
    t_thermal();
    u_host.drive(1'b0, 1'b1);
    u_host.settle(2);
    chk(outs, 11'h03B);
    complete_run();
  end
endmodule : tb
